// ---- shared/phs_pkg.sv ----
package phs_pkg;

	// ----------------------------------------
	// Storage layout
	// ----------------------------------------
	localparam int PHS_UNITS = 16;
	localparam int PHS_STORE_BYTES = 48;
	localparam int PHS_MEM_DEPTH = 64;
	localparam logic [5:0] PHS_ADDR_HOUSE = 6'h01;
	localparam logic [5:0] PHS_ADDR_UNIT = 6'h02;
	localparam logic [5:0] PHS_BASE_HOURS = 6'h10;
	localparam logic [5:0] PHS_BASE_ON_MIN = 6'h20;
	localparam logic [5:0] PHS_BASE_OFF_MIN = 6'h30;

	// Field positions inside the packed bytes
	localparam int PHS_ON_HOUR_LSB = 4;
	localparam int PHS_OFF_HOUR_LSB = 0;
	localparam int PHS_MIN_LSB = 0;
	localparam int PHS_PM_BIT = 7;
	localparam int PHS_LIGHT_BIT = 6;

	// ----------------------------------------
	// Register map of the plain port (own choice)
	// ----------------------------------------
	localparam logic [7:0] PHS_REG_MEM_BASE = 8'h00;
	localparam logic [7:0] PHS_REG_CTRL = 8'h40;
	localparam logic [7:0] PHS_REG_TIME = 8'h41;
	localparam logic [7:0] PHS_REG_TX_HOUSE = 8'h42;
	localparam logic [7:0] PHS_REG_TX_KEY = 8'h43;
	localparam logic [7:0] PHS_REG_STATUS = 8'h44;
	localparam logic [7:0] PHS_REG_RX = 8'h45;
	localparam logic [7:0] PHS_REG_IRQ_STAT = 8'h46;
	localparam logic [7:0] PHS_REG_IRQ_MASK = 8'h47;
	localparam logic [7:0] PHS_REG_PENDING = 8'h48;
	localparam logic [7:0] PHS_REG_BUTTONS = 8'h49;

	// Control register bits
	localparam int PHS_CTRL_INIT = 0;
	localparam int PHS_CTRL_SEND_ADDR = 1;
	localparam int PHS_CTRL_SEND_CMD = 2;
	localparam int PHS_CTRL_RUN = 3;

	// Interrupt bits
	localparam int PHS_IRQ_TX_DONE = 0;
	localparam int PHS_IRQ_RX_DONE = 1;
	localparam int PHS_IRQ_MATCH = 2;
	localparam int PHS_IRQ_MINUTE = 3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int PHS_CLK_HZ = 25_000_000;
	localparam int PHS_TICK_MS = 25;
	localparam int PHS_TICK_CYCLES = PHS_CLK_HZ / 1000 * PHS_TICK_MS;
	localparam int PHS_TICKS_PER_SEC = 40;
	localparam logic [7:0] PHS_RESET_VALUE = 8'h00;

	// Function codes used for scheduled switching
	localparam logic [4:0] PHS_FUNC_ON = 5'h14;
	localparam logic [4:0] PHS_FUNC_OFF = 5'h1c;

	typedef enum {
		PHS_IDLE,
		PHS_SCAN_HOURS,
		PHS_SCAN_ON,
		PHS_SCAN_OFF,
		PHS_SCAN_NEXT,
		PHS_ISSUE_ADDR,
		PHS_ISSUE_CMD
	} phs_state_t;

endpackage

// ---- hdl/phs_scheduler.sv ----
// Summary of operation
// - Five button inputs are active low
// - Sixteen units held in 48 storage bytes
// - Hours packed 4-bit pairs, minutes 6-bit
// - On minute byte has PM and dusk
// - Off minute byte has PM and dawn
// - House address 0x001, unit address 0x002
// - Unit minus one indexes three tables
// - Minute increment raises comparison request
// - Pass compares time with every unit
// - Match sets pending, later sends command
// - Busy flag held during transmission
// - Address send carries house and unit
// - Command send carries house and function
// - Receive done set on complete message
// - Kind flag: address clear, command set
// - Read shows kind, low two house bits, unit/function
module phs_scheduler
	import phs_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Buttons, active low
	input wire logic [4:0] button_n_i,
	// Carrier stage, transmit side
	output logic tx_start_o,
	output logic tx_is_command_o,
	output logic [3:0] tx_house_o,
	output logic [4:0] tx_key_o,
	input wire logic tx_end_i,
	// Carrier stage, receive side
	input wire logic rx_valid_i,
	input wire logic rx_is_command_i,
	input wire logic [3:0] rx_house_i,
	input wire logic [4:0] rx_key_i,
	// Status and interrupt
	output logic tx_busy_flag_o,
	output logic rx_done_flag_o,
	output logic irq_o
);
	import phs_pkg::*;

	// ----------------------------------------
	// Non-volatile image, one array
	// ----------------------------------------
	logic [7:0] store_mem [PHS_MEM_DEPTH]; // Hours, minutes, system bytes

	// All other state in one struct
	typedef struct packed {
		logic [7:0] rdata;
		logic initialised;
		logic run;
		logic [19:0] tick_cnt;
		logic [5:0] tick_in_sec;
		logic [5:0] sec;
		logic [5:0] minute;
		logic [3:0] hour;
		logic pm;
		logic compare_req;
		phs_state_t state;
		logic [3:0] unit_idx;
		logic [3:0] hours_byte;
		logic [15:0] pend_on;
		logic [15:0] pend_off;
		logic [3:0] tx_house_value;
		logic [4:0] tx_key_value;
		logic tx_start;
		logic tx_is_cmd;
		logic tx_busy_flag;
		logic rx_done_flag;
		logic rx_is_command_flag;
		logic [3:0] rx_house_value;
		logic [4:0] rx_key_value;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic irq;
		logic [4:0] pressed;
	} phs_regs_t;

	phs_regs_t cur_reg, cur_next;

	// Decodes a unit slot address; used by the scan only, the bus uses addr_i directly
	function automatic logic [5:0] phs_slot(input logic [5:0] base, input logic [3:0] idx);
		phs_slot = base + {2'h0, idx}; // Unit number minus one
	endfunction

	logic [7:0] mem_q;
	logic [5:0] mem_addr;
	logic mem_we;

	// ----------------------------------------
	// Storage port address select
	// ----------------------------------------
	always_comb begin
		mem_we = wr_i && (addr_i < 8'(PHS_MEM_DEPTH));
		// Scanner owns the read port in its three scan states
		case (cur_reg.state)
			PHS_SCAN_HOURS: mem_addr = phs_slot(PHS_BASE_HOURS, cur_reg.unit_idx);
			PHS_SCAN_ON: mem_addr = phs_slot(PHS_BASE_ON_MIN, cur_reg.unit_idx);
			PHS_SCAN_OFF: mem_addr = phs_slot(PHS_BASE_OFF_MIN, cur_reg.unit_idx);
			default: mem_addr = addr_i[5:0];
		endcase
	end

	// One read port; a bus read during a pass sees the scanned byte instead
	assign mem_q = store_mem[mem_addr];

	// Storage writes, no reset: contents are user data
	always_ff @(posedge mclk_i) begin
		if (mem_we) begin
			store_mem[addr_i[5:0]] <= wdata_i;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic hit_on;
		logic hit_off;
		logic [3:0] ev;
		logic [7:0] rd_val;
		hit_on = 1'b0;
		hit_off = 1'b0;
		ev = 4'h0;
		rd_val = 8'h00;
		cur_next = cur_reg;
		cur_next.tx_start = 1'b0;
		// Sampled every cycle; debouncing is left to software
		cur_next.pressed = ~button_n_i; // Pressed reads as zero on the pin

		// Time of day, 25 ms tick, seconds, minutes, hours
		cur_next.compare_req = cur_reg.compare_req;
		if (cur_reg.run) begin
			if (cur_reg.tick_cnt == 20'(PHS_TICK_CYCLES - 1)) begin
				cur_next.tick_cnt = 20'h0;
				if (cur_reg.tick_in_sec == 6'(PHS_TICKS_PER_SEC - 1)) begin
					cur_next.tick_in_sec = 6'h0;
					if (cur_reg.sec == 6'd59) begin
						cur_next.sec = 6'h0;
						cur_next.compare_req = 1'b1; // Each minute step asks a pass
						ev[PHS_IRQ_MINUTE] = 1'b1;
						if (cur_reg.minute == 6'd59) begin
							cur_next.minute = 6'h0;
							if (cur_reg.hour == 4'd11) begin
								cur_next.pm = ~cur_reg.pm;
							end
							cur_next.hour = (cur_reg.hour == 4'd12) ? 4'd1 : cur_reg.hour + 4'd1;
						end else begin
							cur_next.minute = cur_reg.minute + 6'd1;
						end
					end else begin
						cur_next.sec = cur_reg.sec + 6'd1;
					end
				end else begin
					cur_next.tick_in_sec = cur_reg.tick_in_sec + 6'd1;
				end
			end else begin
				cur_next.tick_cnt = cur_reg.tick_cnt + 20'd1;
			end
		end

		// Schedule pass over all sixteen units
		case (cur_reg.state)
			PHS_IDLE: begin
				// A pass goes before sending, so all matches of a minute are found first
				if (cur_reg.compare_req) begin
					cur_next.compare_req = ev[PHS_IRQ_MINUTE]; // New minute keeps request
					cur_next.unit_idx = 4'h0;
					cur_next.state = PHS_SCAN_HOURS;
				end else if ((cur_reg.pend_on != 16'h0 || cur_reg.pend_off != 16'h0) &&
					cur_reg.initialised && !cur_reg.tx_busy_flag) begin
					cur_next.state = PHS_ISSUE_ADDR;
				end
			end
			PHS_SCAN_HOURS: begin
				cur_next.hours_byte = mem_q[PHS_ON_HOUR_LSB +: 4]; // On hour, high nibble of the packed hour pair
				cur_next.state = PHS_SCAN_ON;
			end
			PHS_SCAN_ON: begin
				// Minute, PM flag and dusk flag share one byte
				hit_on = cur_reg.hours_byte == cur_reg.hour &&
					mem_q[PHS_MIN_LSB +: 6] == cur_reg.minute &&
					mem_q[PHS_PM_BIT] == cur_reg.pm;
				if (hit_on) begin
					cur_next.pend_on[cur_reg.unit_idx] = 1'b1;
					ev[PHS_IRQ_MATCH] = 1'b1;
				end
				cur_next.state = PHS_SCAN_OFF;
			end
			PHS_SCAN_OFF: begin
				cur_next.state = PHS_SCAN_NEXT;
				// Off hour is the low nibble of the same hours byte
				cur_next.hours_byte = store_mem[phs_slot(PHS_BASE_HOURS,
					cur_reg.unit_idx)][PHS_OFF_HOUR_LSB +: 4];
				// Off byte carries PM and dawn flags
				hit_off = cur_next.hours_byte == cur_reg.hour &&
					mem_q[PHS_MIN_LSB +: 6] == cur_reg.minute &&
					mem_q[PHS_PM_BIT] == cur_reg.pm;
				if (hit_off) begin
					cur_next.pend_off[cur_reg.unit_idx] = 1'b1;
					ev[PHS_IRQ_MATCH] = 1'b1;
				end
			end
			PHS_SCAN_NEXT: begin
				cur_next.unit_idx = cur_reg.unit_idx + 4'd1;
				cur_next.state = (cur_reg.unit_idx == 4'd15) ? PHS_IDLE : PHS_SCAN_HOURS;
			end
			PHS_ISSUE_ADDR: begin
				if (cur_reg.tx_busy_flag) begin
					// A software send took the stage meanwhile; retry once it is free
					cur_next.state = PHS_IDLE;
				end else begin
					// Lowest pending unit first; address message then command
					cur_next.unit_idx = 4'h0;
					for (int i = PHS_UNITS - 1; i >= 0; i--) begin
						if (cur_reg.pend_on[i] || cur_reg.pend_off[i]) begin
							cur_next.unit_idx = 4'(i);
						end
					end
					cur_next.tx_house_value = store_mem[PHS_ADDR_HOUSE][3:0];
					cur_next.tx_key_value = {1'b0, cur_next.unit_idx};
					cur_next.tx_is_cmd = 1'b0;
					cur_next.tx_start = 1'b1;
					cur_next.tx_busy_flag = 1'b1;
					cur_next.state = PHS_ISSUE_CMD;
				end
			end
			PHS_ISSUE_CMD: begin
				// Command only once the address message has fully gone out
				if (!cur_reg.tx_busy_flag) begin
					cur_next.tx_key_value = cur_reg.pend_on[cur_reg.unit_idx] ?
						PHS_FUNC_ON : PHS_FUNC_OFF;
					cur_next.tx_is_cmd = 1'b1;
					cur_next.tx_start = 1'b1;
					cur_next.tx_busy_flag = 1'b1;
					cur_next.pend_on[cur_reg.unit_idx] = 1'b0;
					cur_next.pend_off[cur_reg.unit_idx] = 1'b0;
					cur_next.state = PHS_IDLE;
				end
			end
			default: cur_next.state = PHS_IDLE;
		endcase

		// Transmit end from the carrier stage, after repetition
		// An end pulse in the start cycle is ignored: that frame cannot be over yet
		if (tx_end_i && cur_reg.tx_busy_flag && !cur_reg.tx_start) begin
			cur_next.tx_busy_flag = 1'b0;
			ev[PHS_IRQ_TX_DONE] = 1'b1;
		end

		// Receive capture; a new message overwrites unread data
		// Kind flag is stored with the message it came with
		if (rx_valid_i) begin
			cur_next.rx_done_flag = 1'b1;
			cur_next.rx_is_command_flag = rx_is_command_i;
			cur_next.rx_house_value = rx_house_i;
			cur_next.rx_key_value = rx_key_i;
			ev[PHS_IRQ_RX_DONE] = 1'b1;
		end

		// Register writes
		if (wr_i) begin
			case (addr_i)
				PHS_REG_CTRL: begin
					if (wdata_i[PHS_CTRL_INIT]) begin
						cur_next.initialised = 1'b1;
					end
					cur_next.run = wdata_i[PHS_CTRL_RUN];
					// Software send is refused while busy or not initialised
					if ((wdata_i[PHS_CTRL_SEND_ADDR] || wdata_i[PHS_CTRL_SEND_CMD]) &&
						cur_reg.initialised && !cur_reg.tx_busy_flag &&
						cur_reg.state == PHS_IDLE) begin
						cur_next.tx_is_cmd = wdata_i[PHS_CTRL_SEND_CMD];
						cur_next.tx_start = 1'b1;
						cur_next.tx_busy_flag = 1'b1;
					end
				end
				PHS_REG_TIME: begin
					cur_next.hour = wdata_i[3:0];
					cur_next.pm = wdata_i[4];
				end
				PHS_REG_STATUS: begin
					// Setting the minute is a minute change, so a pass follows
					cur_next.minute = wdata_i[5:0];
					cur_next.sec = 6'h0;
					cur_next.tick_in_sec = 6'h0;
					cur_next.tick_cnt = 20'h0;
					cur_next.compare_req = 1'b1;
				end
				PHS_REG_TX_HOUSE: cur_next.tx_house_value = wdata_i[3:0];
				PHS_REG_TX_KEY: cur_next.tx_key_value = wdata_i[4:0];
				PHS_REG_IRQ_MASK: cur_next.irq_mask = wdata_i[3:0];
				default: begin
				end
			endcase
		end

		// Register reads, data one cycle later
		if (rd_i) begin
			if (addr_i < 8'(PHS_MEM_DEPTH)) begin
				rd_val = mem_q;
			end else begin
				case (addr_i)
					PHS_REG_CTRL: rd_val = {4'h0, cur_reg.run, 2'b00, cur_reg.initialised};
					PHS_REG_TIME: rd_val = {3'h0, cur_reg.pm, cur_reg.hour};
					PHS_REG_TX_HOUSE: rd_val = {4'h0, cur_reg.tx_house_value};
					PHS_REG_TX_KEY: rd_val = {3'h0, cur_reg.tx_key_value};
					PHS_REG_STATUS: rd_val = {2'h0, cur_reg.minute};
					PHS_REG_RX: begin
						// Kind flag, low two house bits, then unit or function code
						rd_val = {cur_reg.rx_is_command_flag, cur_reg.rx_house_value[1:0],
							cur_reg.rx_key_value};
						if (!rx_valid_i) begin
							cur_next.rx_done_flag = 1'b0;
						end
					end
					PHS_REG_IRQ_STAT: begin
						rd_val = {4'h0, cur_reg.irq_stat};
						cur_next.irq_stat = ev; // Clear on read, new events win
					end
					PHS_REG_IRQ_MASK: rd_val = {4'h0, cur_reg.irq_mask};
					PHS_REG_PENDING: rd_val = {cur_reg.tx_busy_flag, cur_reg.rx_done_flag,
						cur_reg.rx_house_value, cur_reg.pend_on[0], cur_reg.pend_off[0]};
					PHS_REG_BUTTONS: rd_val = {3'h0, cur_reg.pressed};
					default: rd_val = 8'h00;
				endcase
			end
		end
		cur_next.rdata = rd_val;

		// Sticky status, set wins over clear
		if (!(rd_i && addr_i == PHS_REG_IRQ_STAT)) begin
			cur_next.irq_stat = cur_reg.irq_stat | ev;
		end
		// Level interrupt from the updated status and mask, so it tracks them at once
		cur_next.irq = |(cur_next.irq_stat & cur_next.irq_mask);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// 12:00 AM with the clock stopped, nothing pending
			cur_reg <= '0;
			cur_reg.hour <= 4'd12;
			cur_reg.state <= PHS_IDLE;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// Outputs straight from flip-flops
	assign rdata_o = cur_reg.rdata;
	assign tx_start_o = cur_reg.tx_start;
	assign tx_is_command_o = cur_reg.tx_is_cmd;
	assign tx_house_o = cur_reg.tx_house_value;
	assign tx_key_o = cur_reg.tx_key_value;
	assign tx_busy_flag_o = cur_reg.tx_busy_flag;
	assign rx_done_flag_o = cur_reg.rx_done_flag;
	assign irq_o = cur_reg.irq;

endmodule

// ---- tb/phs_chk.sv ----
// ----------------------------------------
// Port checker for the scheduler
// ----------------------------------------
module phs_chk
	import phs_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Carrier stage
	input wire logic tx_start_o,
	input wire logic tx_end_i,
	input wire logic rx_valid_i,
	input wire logic rx_is_command_i,
	input wire logic [3:0] rx_house_i,
	input wire logic [4:0] rx_key_i,
	// Flags
	input wire logic tx_busy_flag_o,
	input wire logic rx_done_flag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx_word_reg; // Last message as the rx register should show it

	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Own copy of the last message, so reads are judged without the design
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_word_reg <= 8'h00;
		end else if (rx_valid_i) begin
			rx_word_reg <= {rx_is_command_i, rx_house_i[1:0], rx_key_i};
		end
	end

	// A read of a waiting message, not overlapped by a new arrival
	sequence s_rx_read;
		rd_i && addr_i == PHS_REG_RX && rx_done_flag_o && !rx_valid_i;
	endsequence
	// Start pulse and busy flag rise together
	sequence s_tx_open;
		tx_start_o && tx_busy_flag_o;
	endsequence

	property p_start_busy;
		tx_start_o |-> s_tx_open;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("busy low at start");
	property p_busy_hold;
		tx_busy_flag_o && !tx_end_i |=> tx_busy_flag_o;
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped early");
	property p_busy_clear;
		tx_busy_flag_o && tx_end_i |=> !tx_busy_flag_o;
	endproperty
	a_busy_clear: assert property (p_busy_clear)
		else $error("busy held after end");
	property p_no_restart;
		tx_busy_flag_o && !tx_end_i |=> !tx_start_o;
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("start while busy");
	property p_rx_done;
		rx_valid_i |=> rx_done_flag_o;
	endproperty
	a_rx_done: assert property (p_rx_done)
		else $error("rx done missing");
	property p_rx_rose;
		$rose(rx_done_flag_o) |-> $past(rx_valid_i);
	endproperty
	a_rx_rose: assert property (p_rx_rose)
		else $error("rx done without message");
	property p_rx_clear;
		s_rx_read |=> !rx_done_flag_o;
	endproperty
	a_rx_clear: assert property (p_rx_clear)
		else $error("rx done kept after read");
	property p_rx_word;
		s_rx_read |=> rdata_o == rx_word_reg;
	endproperty
	a_rx_word: assert property (p_rx_word)
		else $error("rx word wrong");
endmodule

bind phs_scheduler phs_chk u_chk (
	.mclk_i(mclk_i),
	.rst_n_i(rst_n_i),
	.addr_i(addr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.tx_start_o(tx_start_o),
	.tx_end_i(tx_end_i),
	.rx_valid_i(rx_valid_i),
	.rx_is_command_i(rx_is_command_i),
	.rx_house_i(rx_house_i),
	.rx_key_i(rx_key_i),
	.tx_busy_flag_o(tx_busy_flag_o),
	.rx_done_flag_o(rx_done_flag_o)
);

// ---- tb/phs_carrier_model.sv ----
// ----------------------------------------
// Carrier stage model
// ----------------------------------------
module phs_carrier_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Transmit side
	input wire logic tx_start_i,
	input wire logic [7:0] frame_len_i,
	output logic tx_end_o,
	// Receive side
	output logic rx_valid_o,
	output logic rx_is_command_o,
	output logic [3:0] rx_house_o,
	output logic [4:0] rx_key_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt; // Cycles left in the frame, both copies included

	initial begin
		rx_valid_o = 1'b0;
		rx_is_command_o = 1'b0;
		rx_house_o = 4'h0;
		rx_key_o = 5'h00;
	end

	// End pulse only after the repeated block has gone out
	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
			tx_end_o <= 1'b0;
		end else begin
			tx_end_o <= (cnt == 1);
			if (tx_start_i) begin
				cnt <= int'(frame_len_i);
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end

	// One complete message; lines then show the inverse, being undriven
	task automatic push_rx(input logic k, input logic [3:0] h, input logic [4:0] u);
		@(posedge mclk_i);
		rx_valid_o <= 1'b1;
		rx_is_command_o <= k;
		rx_house_o <= h;
		rx_key_o <= u;
		@(posedge mclk_i);
		rx_valid_o <= 1'b0;
		rx_is_command_o <= ~k;
		rx_house_o <= ~h;
		rx_key_o <= ~u;
	endtask
endmodule

// ---- tb/phs_scheduler_tb.sv ----
// ----------------------------------------
// Bench for the scheduler
// ----------------------------------------
module phs_scheduler_tb;
	import phs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [4:0] button_n_i = 5'h1f;
	logic [7:0] frame_len = 8'h03; // Prompt or slow carrier
	logic [7:0] rdata_o, a, v;
	logic tx_start_o, tx_is_command_o, tx_end_i, rx_valid_i, rx_is_command_i;
	logic [3:0] tx_house_o, rx_house_i, h;
	logic [4:0] tx_key_o, rx_key_i, u;
	logic tx_busy_flag_o, rx_done_flag_o, irq_o, q0, q1;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	int t; // Expected PM and minute bits of a matching minute byte
	logic [15:0] tx_word; // Frame the stage is asked to send
	int mem [64]; // Storage image
	int txq [$]; // Frames expected on the carrier

	always #20 mclk_i = ~mclk_i;
	assign tx_word = {6'h0, tx_is_command_o, tx_house_o, tx_key_o};

	phs_scheduler dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.button_n_i(button_n_i), .tx_start_o(tx_start_o),
		.tx_is_command_o(tx_is_command_o), .tx_house_o(tx_house_o), .tx_key_o(tx_key_o),
		.tx_end_i(tx_end_i), .rx_valid_i(rx_valid_i), .rx_is_command_i(rx_is_command_i),
		.rx_house_i(rx_house_i), .rx_key_i(rx_key_i), .tx_busy_flag_o(tx_busy_flag_o),
		.rx_done_flag_o(rx_done_flag_o), .irq_o(irq_o));
	phs_carrier_model u_carrier (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.tx_start_i(tx_start_o), .frame_len_i(frame_len), .tx_end_o(tx_end_i),
		.rx_valid_o(rx_valid_i), .rx_is_command_o(rx_is_command_i),
		.rx_house_o(rx_house_i), .rx_key_o(rx_key_i));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus_wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= ad;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= ad;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	// Bounded wait; the busy flag must fall once the frame ends
	task automatic wait_idle();
		int n;
		n = 0;
		while (tx_busy_flag_o !== 1'b0 && n < 300) begin
			@(posedge mclk_i);
			n++;
		end
		chk("tx busy", 16'h0, {15'h0, tx_busy_flag_o});
	endtask
	task automatic mask_irq(input logic [7:0] m, output logic q);
		bus_wr(PHS_REG_IRQ_MASK, m);
		repeat (2) @(posedge mclk_i);
		#1;
		q = irq_o;
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Hang guard, far above the roughly one thousand cycles the run needs
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// Every start must match the oldest frame asked for
	always @(posedge mclk_i) begin
		if (tx_start_o === 1'b1) begin
			if (txq.size() == 0) begin
				chk("tx start", 16'h0, 16'h1);
			end else begin
				chk("tx frame", 16'(txq.pop_front()), tx_word);
			end
		end
	end

	initial begin
		void'($urandom(12666));
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		// Two address bytes and three bytes for each of the units
		for (int i = 0; i < 50; i++) begin
			a = (i < 2) ? 8'(i + 1) : 8'(16 * ((i - 2) / 16 + 1) + (i - 2) % 16);
			mem[a] = int'(8'($urandom));
			bus_wr(a, 8'(mem[a]));
		end
		for (int i = 0; i < 50; i++) begin
			a = (i < 2) ? 8'(i + 1) : 8'(16 * ((i - 2) / 16 + 1) + (i - 2) % 16);
			bus_rd(a, v);
			chk("store", 16'(mem[a]), {8'h0, v});
		end
		$display("test storage done");
		button_n_i <= 5'($urandom);
		repeat (4) @(posedge mclk_i);
		bus_rd(PHS_REG_BUTTONS, v);
		chk("buttons", {11'h0, ~button_n_i}, {8'h0, v});
		bus_rd(8'h4f, v);
		chk("unmapped", 16'h0, {8'h0, v});
		$display("test buttons done");
		// A send before the link is set up is refused
		bus_wr(PHS_REG_CTRL, 8'h02);
		repeat (3) @(posedge mclk_i);
		chk("busy early", 16'h0, {15'h0, tx_busy_flag_o});
		bus_wr(PHS_REG_CTRL, 8'h01);
		for (int k = 0; k < 4; k++) begin
			h = 4'($urandom);
			u = 5'($urandom);
			frame_len <= (k < 2) ? 8'h03 : 8'h28;
			bus_wr(PHS_REG_TX_HOUSE, {4'h0, h});
			bus_wr(PHS_REG_TX_KEY, {3'h0, u});
			txq.push_back({1'(k), h, u});
			bus_wr(PHS_REG_CTRL, k[0] ? 8'h04 : 8'h02);
			bus_wr(PHS_REG_CTRL, 8'h02);
			wait_idle();
			chk("frames left", 16'h0, 16'(txq.size()));
		end
		$display("test transmit done");
		bus_rd(PHS_REG_IRQ_STAT, v);
		for (int k = 0; k < 2; k++) begin
			h = 4'($urandom);
			u = 5'($urandom);
			u_carrier.push_rx(1'(k), h, u);
			#1;
			chk("rx done", 16'h1, {15'h0, rx_done_flag_o});
			mask_irq(8'h00, q0);
			mask_irq(8'hff, q1);
			chk("irq masked", 16'h0, {15'h0, q0});
			chk("irq open", 16'h1, {15'h0, q1});
			bus_rd(PHS_REG_IRQ_STAT, v);
			chk("irq status", 16'h2, {8'h0, v});
			repeat (2) @(posedge mclk_i);
			#1;
			chk("irq clear", 16'h0, {15'h0, irq_o});
			bus_rd(PHS_REG_RX, v);
			chk("rx word", {8'h0, 1'(k), h[1:0], u}, {8'h0, v});
			chk("rx cleared", 16'h0, {15'h0, rx_done_flag_o});
		end
		$display("test receive done");
		// Scheduled switching: one unit is set to match, the rest as stored
		frame_len <= 8'h03;
		h = 4'($urandom_range(12, 1));
		q0 = 1'($urandom);
		v = 8'($urandom_range(59, 0));
		u = 5'($urandom_range(15, 0));
		t = q0 * 128 + v;
		mem[16 + u] = h * 16 + (mem[16 + u] & 15);
		mem[32 + u] = t + (mem[32 + u] & 64);
		bus_wr(8'(16 + u), 8'(mem[16 + u]));
		bus_wr(8'(32 + u), 8'(mem[32 + u]));
		bus_wr(PHS_REG_TIME, {3'h0, q0, h});
		// Model: units in rising order, each an address then its command
		for (int j = 0; j < 16; j++) begin
			q1 = (mem[16 + j] >> 4) == h && (mem[32 + j] & 191) == t;
			if (q1 || ((mem[16 + j] & 15) == h && (mem[48 + j] & 191) == t)) begin
				txq.push_back({1'b0, 4'(mem[1]), 5'(j)});
				txq.push_back({1'b1, 4'(mem[1]), q1 ? PHS_FUNC_ON : PHS_FUNC_OFF});
			end
		end
		bus_wr(PHS_REG_STATUS, v);
		repeat (600) @(posedge mclk_i);
		chk("frames left", 16'h0, 16'(txq.size()));
		chk("tx busy", 16'h0, {15'h0, tx_busy_flag_o});
		bus_rd(PHS_REG_STATUS, a);
		chk("minute", {8'h0, v}, {8'h0, a});
		$display("test schedule done");
		report_and_stop();
	end
endmodule
